/* hdl/tmsp_top.sv */
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tmsp_top
	import tmsp_pkg::*;
#(
	parameter logic [7:0] ID_ROM_SEED   = 8'h5A,  // arbitrary identity fill
	parameter logic [7:0] DIAG_ROM_SEED = 8'hC3   // arbitrary factory fill
)
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        CE,
	input  wire logic        TX_DISABLE_PIN,
	input  wire logic        TX_DISABLE_DRIVEN,
	output logic             TX_LASER_ON,
	input  wire logic        LASER_FAULT,
	input  wire logic        RX_POWER_LOW,
	output logic             TX_FAULT_OUT,
	output logic             TX_FAULT_OE,
	output logic             RECEIVE_POWER_LOST_OUT,
	output logic             RECEIVE_POWER_LOST_OE,
	output logic             MODULE_PRESENT_LINE_OUT,
	output logic             MODULE_PRESENT_LINE_OE,
	input  wire logic        ID_SERIAL_CLOCK_LINE,
	input  wire logic        ID_SERIAL_DATA_LINE_IN,
	output logic             ID_SERIAL_DATA_LINE_OUT,
	output logic             ID_SERIAL_DATA_LINE_OE,
	input  wire logic [79:0] MON_RAW,
	input  wire logic        MON_VALID,
	input  wire logic [1:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	output logic             IRQ
);
	tmsp_link_if lnk ();
	tmsp_state_e state_q;
	logic [2:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  addr_q;
	logic        diag_sel_q;
	logic        read_q;
	logic        sda_low_q;
	logic        armed_q;
	logic [7:0]  id_mem   [MEM_WORDS];
	logic [7:0]  diag_mem [MEM_WORDS];
	logic [1:0]  ctrl_q;
	logic [3:0]  status_q;
	logic [3:0]  mask_q;
	logic [3:0]  event_d;
	logic [1:0]  tx_dis_sync_q;
	logic [7:0]  rd_byte;
	logic        my_addr;

	// true where host writes land; identity and factory areas stay fixed
	function automatic logic writable(input logic diag, input logic [7:0] a);
		writable = diag && (a >= USER_FIRST);
	endfunction : writable

	function automatic logic [7:0] factory_byte(input logic [7:0] seed, input logic [7:0] a);
		factory_byte = seed ^ a;
	endfunction : factory_byte

	tmsp_edge u_edge
	(
		.clk     (CLK),
		.ce      (CE),
		.rst_b   (RST_B),
		.scl_pin (ID_SERIAL_CLOCK_LINE),
		.sda_pin (ID_SERIAL_DATA_LINE_IN),
		.lnk     (lnk)
	);

	// open pin reads as disabled, like the pull-up
	always_ff @(posedge CLK)
		if (!RST_B)
			tx_dis_sync_q <= 2'h3;
		else if (CE)
			tx_dis_sync_q <= {tx_dis_sync_q[0], TX_DISABLE_PIN || !TX_DISABLE_DRIVEN};
	assign TX_LASER_ON = !tx_dis_sync_q[1];

	// open drain: released means high, driven means low
	assign TX_FAULT_OUT = 1'b0;
	assign TX_FAULT_OE  = !(LASER_FAULT || ctrl_q[CTRL_LASER_FAULT]);
	assign RECEIVE_POWER_LOST_OUT = 1'b0;
	assign RECEIVE_POWER_LOST_OE  = !(RX_POWER_LOW || ctrl_q[CTRL_RX_LOST]);
	assign MODULE_PRESENT_LINE_OUT = 1'b0;
	assign MODULE_PRESENT_LINE_OE  = 1'b1;

	// scl is never driven, only sampled
	assign ID_SERIAL_DATA_LINE_OUT = 1'b0;
	assign ID_SERIAL_DATA_LINE_OE  = sda_low_q;

	assign my_addr = (shift_q[7:1] == ID_DEV_ADDR) || (shift_q[7:1] == DIAG_DEV_ADDR);
	assign rd_byte = diag_sel_q ? diag_mem[addr_q] : id_mem[addr_q];

	// serial target state machine
	always_ff @(posedge CLK)
		if (!RST_B)
		begin
			state_q    <= TMSP_IDLE;
			bit_cnt_q  <= 3'h0;
			shift_q    <= 8'h00;
			addr_q     <= 8'h00;
			diag_sel_q <= 1'b0;
			read_q     <= 1'b0;
			sda_low_q  <= 1'b0;
			armed_q    <= 1'b0;
		end
		else if (lnk.start_seen)
		begin
			state_q   <= TMSP_DEVADR;
			bit_cnt_q <= 3'h0;
			sda_low_q <= 1'b0;
			// the clock fall that closes a start is not a bit boundary
			armed_q   <= 1'b0;
		end
		else if (lnk.stop_seen)
		begin
			state_q   <= TMSP_IDLE;
			sda_low_q <= 1'b0;
		end
		else if (lnk.scl_rise)
		begin
			armed_q <= 1'b1;
			case (state_q)
				TMSP_DEVADR, TMSP_WADDR, TMSP_WDATA:
				begin
					shift_q   <= {shift_q[6:0], lnk.sda_in};
					bit_cnt_q <= bit_cnt_q + 3'h1;
				end
				TMSP_RACK:
					// host nack ends a sequential read; ack waits for the fall
					if (lnk.sda_in)
						state_q <= TMSP_IDLE;
				default:
					state_q <= state_q;
			endcase
		end
		else if (lnk.scl_fall)
		begin
			case (state_q)
				TMSP_DEVADR:
					if (bit_cnt_q == 3'h0 && armed_q)
					begin
						if (my_addr)
						begin
							diag_sel_q <= shift_q[1];
							read_q     <= shift_q[0];
							sda_low_q  <= 1'b1;
							state_q    <= TMSP_DEVACK;
						end
						else
							state_q <= TMSP_IDLE;
					end
				TMSP_DEVACK:
					if (read_q)
					begin
						state_q   <= TMSP_RDATA;
						shift_q   <= rd_byte;
						sda_low_q <= !rd_byte[7];
						bit_cnt_q <= 3'h1;
					end
					else
					begin
						state_q   <= TMSP_WADDR;
						sda_low_q <= 1'b0;
					end
				TMSP_WADDR, TMSP_WDATA:
					if (bit_cnt_q == 3'h0)
					begin
						sda_low_q <= 1'b1;
						state_q   <= TMSP_WACK;
						if (state_q == TMSP_WADDR)
							addr_q <= shift_q;
						else
							addr_q <= addr_q + 8'h01;
					end
				TMSP_WACK:
				begin
					sda_low_q <= 1'b0;
					state_q   <= TMSP_WDATA;
				end
				TMSP_RDATA:
					if (bit_cnt_q == 3'h0)
					begin
						sda_low_q <= 1'b0;
						addr_q    <= addr_q + 8'h01;
						state_q   <= TMSP_RACK;
					end
					else
					begin
						sda_low_q <= !shift_q[~bit_cnt_q];
						bit_cnt_q <= bit_cnt_q + 3'h1;
					end
				TMSP_RACK:
				begin
					state_q   <= TMSP_RDATA;
					shift_q   <= rd_byte;
					sda_low_q <= !rd_byte[7];
					bit_cnt_q <= 3'h1;
				end
				default:
					sda_low_q <= 1'b0;
			endcase
		end

	// factory image at reset; monitor slots refreshed live
	genvar gi;
	generate
		for (gi = 0; gi < MEM_WORDS; gi++)
		begin : g_mem
			localparam logic [7:0] A = 8'(gi);
			// clamped so slots outside the monitor range never index past the bus
			localparam int MI = (gi >= int'(MON_FIRST) && gi <= int'(MON_LAST))
				? gi - int'(MON_FIRST) : 0;
			always_ff @(posedge CLK)
				if (!RST_B)
				begin
					id_mem[gi]   <= factory_byte(ID_ROM_SEED, A);
					diag_mem[gi] <= (A >= CAL_FIRST && A <= CAL_LAST)
						? factory_byte(DIAG_ROM_SEED, A) : ROM_FILL;
				end
				else if (CE)
				begin
					if (A >= MON_FIRST && A <= MON_LAST && MON_VALID)
						diag_mem[gi] <= MON_RAW[8*MI +: 8];
					else if (lnk.scl_fall && state_q == TMSP_WDATA && bit_cnt_q == 3'h0
						&& diag_sel_q && addr_q == A && writable(diag_sel_q, A))
						diag_mem[gi] <= shift_q;
				end
		end
	endgenerate

	always_comb
	begin
		event_d = 4'h0;
		event_d[IRQ_STARTED] = lnk.start_seen;
		event_d[IRQ_STOPPED] = lnk.stop_seen;
		event_d[IRQ_WRITTEN] = lnk.scl_fall && state_q == TMSP_WDATA && bit_cnt_q == 3'h0
			&& writable(diag_sel_q, addr_q);
		event_d[IRQ_PROTECTED] = lnk.scl_fall && state_q == TMSP_WDATA && bit_cnt_q == 3'h0
			&& !writable(diag_sel_q, addr_q);
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge CLK)
		if (!RST_B)
			status_q <= IRQ_RESET;
		else if (CE)
			status_q <= (status_q & ~((REG_WR && REG_ADDR == REG_STATUS) ? REG_WDATA[3:0] : 4'h0))
				| event_d;

	always_ff @(posedge CLK)
		if (!RST_B)
		begin
			mask_q <= IRQ_RESET;
			ctrl_q <= 2'h0;
		end
		else if (CE && REG_WR)
		begin
			if (REG_ADDR == REG_MASK)
				mask_q <= REG_WDATA[3:0];
			if (REG_ADDR == REG_CTRL)
				ctrl_q <= REG_WDATA[1:0];
		end

	always_ff @(posedge CLK)
		if (!RST_B)
			REG_RDATA <= 8'h00;
		else if (CE)
		begin
			if (!REG_RD)
				REG_RDATA <= 8'h00;
			else
				case (REG_ADDR)
					REG_STATUS: REG_RDATA <= {4'h0, status_q};
					REG_MASK:   REG_RDATA <= {4'h0, mask_q};
					REG_CTRL:   REG_RDATA <= {6'h00, ctrl_q};
					REG_PINS:   REG_RDATA <= {TX_LASER_ON, !TX_FAULT_OE, !RECEIVE_POWER_LOST_OE,
						read_q, 1'b0, 3'(state_q)};
					default:    REG_RDATA <= 8'h00;
				endcase
		end

	assign IRQ = |(status_q & mask_q);
endmodule : tmsp_top
`default_nettype wire

/* pkg/tmsp_pkg.sv */
`default_nettype none
package tmsp_pkg;
	localparam logic [6:0] ID_DEV_ADDR   = 7'h50;  // A0h byte
	localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;  // A2h byte
	localparam logic [7:0] CAL_FIRST     = 8'h38;  // 56
	localparam logic [7:0] CAL_LAST      = 8'h5F;  // 95
	localparam logic [7:0] MON_FIRST     = 8'h60;
	localparam logic [7:0] MON_LAST      = 8'h69;
	localparam logic [7:0] USER_FIRST    = 8'h80;
	localparam int         MEM_WORDS     = 256;
	localparam logic [7:0] ROM_FILL      = 8'h00;
	localparam int         MON_CHANNELS  = 5;
	localparam logic [3:0] IRQ_RESET     = 4'h0;
	localparam int         IRQ_STARTED   = 0;
	localparam int         IRQ_STOPPED   = 1;
	localparam int         IRQ_WRITTEN   = 2;
	localparam int         IRQ_PROTECTED = 3;
	localparam logic [1:0] REG_STATUS    = 2'h0;
	localparam logic [1:0] REG_MASK      = 2'h1;
	localparam logic [1:0] REG_CTRL      = 2'h2;
	localparam logic [1:0] REG_PINS      = 2'h3;
	localparam int         CTRL_LASER_FAULT = 0;
	localparam int         CTRL_RX_LOST     = 1;
	typedef enum logic [2:0] {
		TMSP_IDLE, TMSP_DEVADR, TMSP_DEVACK, TMSP_WADDR, TMSP_WACK,
		TMSP_WDATA, TMSP_RDATA, TMSP_RACK
	} tmsp_state_e;
endpackage : tmsp_pkg
`default_nettype wire

/* pkg/tmsp_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface tmsp_link_if;
	logic       scl_rise;
	logic       scl_fall;
	logic       sda_in;
	logic       start_seen;
	logic       stop_seen;
	modport edge_side (output scl_rise, output scl_fall, output sda_in,
		output start_seen, output stop_seen);
	modport core_side (input scl_rise, input scl_fall, input sda_in,
		input start_seen, input stop_seen);
endinterface : tmsp_link_if
`default_nettype wire

/* hdl/tmsp_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module tmsp_edge
(
	input  wire logic    clk,
	input  wire logic    ce,
	input  wire logic    rst_b,
	input  wire logic    scl_pin,
	input  wire logic    sda_pin,
	tmsp_link_if.edge_side lnk
);
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic       scl_prev_q;
	logic       sda_prev_q;

	// two flops before anything looks at the pins
	always_ff @(posedge clk)
		if (!rst_b)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else if (ce)
		begin
			scl_sync_q <= {scl_sync_q[0], scl_pin};
			sda_sync_q <= {sda_sync_q[0], sda_pin};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end

	assign lnk.sda_in     = sda_sync_q[1];
	assign lnk.scl_rise   = ce && scl_sync_q[1] && !scl_prev_q;
	assign lnk.scl_fall   = ce && !scl_sync_q[1] && scl_prev_q;
	// sda moving while scl high frames a transaction
	assign lnk.start_seen = ce && scl_sync_q[1] && scl_prev_q && !sda_sync_q[1] && sda_prev_q;
	assign lnk.stop_seen  = ce && scl_sync_q[1] && scl_prev_q && sda_sync_q[1] && !sda_prev_q;
endmodule : tmsp_edge
`default_nettype wire

/* bench/tmsp_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module tmsp_top_properties
	import tmsp_pkg::*;
(
	input wire logic       CLK,
	input wire logic       RST_B,
	input wire logic       TX_DISABLE_PIN,
	input wire logic       TX_DISABLE_DRIVEN,
	input wire logic       TX_LASER_ON,
	input wire logic       LASER_FAULT,
	input wire logic       RX_POWER_LOW,
	input wire logic       TX_FAULT_OUT,
	input wire logic       TX_FAULT_OE,
	input wire logic       RECEIVE_POWER_LOST_OE,
	input wire logic       MODULE_PRESENT_LINE_OUT,
	input wire logic       MODULE_PRESENT_LINE_OE,
	input wire logic       ID_SERIAL_CLOCK_LINE,
	input wire logic       ID_SERIAL_DATA_LINE_OUT,
	input wire logic       ID_SERIAL_DATA_LINE_OE,
	input wire logic [1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       IRQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	property p_present;
		MODULE_PRESENT_LINE_OE && !MODULE_PRESENT_LINE_OUT;
	endproperty
	a_present: assert property (p_present)
		else $error("present line not grounded");
	property p_fault;
		LASER_FAULT |-> !TX_FAULT_OE && !TX_FAULT_OUT;
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault line not released");
	property p_loss;
		RX_POWER_LOW |-> !RECEIVE_POWER_LOST_OE;
	endproperty
	a_loss: assert property (p_loss)
		else $error("loss line not released");
	// two sync stages, so the laser may lag the pin by two edges
	property p_laser;
		(TX_DISABLE_PIN || !TX_DISABLE_DRIVEN) |=> ##1 !TX_LASER_ON;
	endproperty
	a_laser: assert property (p_laser)
		else $error("laser on while disabled");
	property p_sda_low;
		ID_SERIAL_DATA_LINE_OUT == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low)
		else $error("data line driven high");
	property p_sda_turn;
		$changed(ID_SERIAL_DATA_LINE_OE) |-> !ID_SERIAL_CLOCK_LINE;
	endproperty
	a_sda_turn: assert property (p_sda_turn)
		else $error("data changed with clock high");
	property p_irq_mask;
		REG_WR && REG_ADDR == REG_MASK && REG_WDATA == 8'h00 |=> !IRQ;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq with mask cleared");
	property p_rd_idle;
		!REG_RD |=> REG_RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	c_ack: cover property ($rose(ID_SERIAL_DATA_LINE_OE));
	c_irq: cover property ($rose(IRQ));
	c_laser: cover property ($rose(TX_LASER_ON));
endmodule : tmsp_top_properties
bind tmsp_top tmsp_top_properties u_props (.*);
`default_nettype wire

/* bench/tmsp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module tmsp_host
(
	output logic      scl,
	output logic      pull,
	input  wire logic sda
);
	// clock parked high between frames; low phase longer for sync lag
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic start;
		#13 pull = 1'b0;
		#80 scl = 1'b1;
		#80 pull = 1'b1;
		#80 scl = 1'b0;
		#80;
	endtask : start
	task automatic stop;
		pull = 1'b1;
		#80 scl = 1'b1;
		#80 pull = 1'b0;
		#80;
	endtask : stop
	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		#120 scl = 1'b1;
		#60 r = sda;
		#60 scl = 1'b0;
		#80;
	endtask : bit_io
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : send
	task automatic recv(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask : recv
endmodule : tmsp_host
`default_nettype wire

/* bench/tmsp_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module transceiver_mgmt_status_port_bench
	import tmsp_pkg::*;
;
	localparam logic [7:0] ID_SEED = 8'h5A;  // arbitrary
	localparam logic [7:0] DIAG_SEED = 8'hC3;  // arbitrary
	logic CLK, RST_B, CE, TX_DISABLE_PIN, TX_DISABLE_DRIVEN, TX_LASER_ON, LASER_FAULT;
	logic RX_POWER_LOW, TX_FAULT_OUT, TX_FAULT_OE, RECEIVE_POWER_LOST_OUT;
	logic RECEIVE_POWER_LOST_OE, MODULE_PRESENT_LINE_OUT, MODULE_PRESENT_LINE_OE;
	logic ID_SERIAL_CLOCK_LINE, ID_SERIAL_DATA_LINE_OUT, ID_SERIAL_DATA_LINE_OE;
	logic MON_VALID, REG_WR, REG_RD, IRQ, host_pull;
	logic [79:0] MON_RAW;
	logic [1:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA, d;
	wire logic ID_SERIAL_DATA_LINE_IN;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	// pull-up: high unless someone pulls low
	assign ID_SERIAL_DATA_LINE_IN = !(host_pull | ID_SERIAL_DATA_LINE_OE);
	tmsp_top #(.ID_ROM_SEED(ID_SEED), .DIAG_ROM_SEED(DIAG_SEED)) DUT (.*);
	tmsp_host u_host (.scl(ID_SERIAL_CLOCK_LINE), .pull(host_pull), .sda(ID_SERIAL_DATA_LINE_IN));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : wait_cyc
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= v;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [1:0] a);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask : reg_rd
	task automatic tx(input logic [7:0] b, input logic exp_ack);
		logic ack;
		u_host.send(b, ack);
		chk("ack", ack, exp_ack);
	endtask : tx
	task automatic mem_wr(input logic [6:0] dv, input logic [7:0] a, v0, v1);
		u_host.start();
		tx({dv, 1'b0}, 1'b1);
		tx(a, 1'b1);
		tx(v0, 1'b1);
		tx(v1, 1'b1);
		u_host.stop();
	endtask : mem_wr
	task automatic mem_rd(input logic [6:0] dv, input logic [7:0] a, e0, e1);
		u_host.start();
		tx({dv, 1'b0}, 1'b1);
		tx(a, 1'b1);
		u_host.start();
		tx({dv, 1'b1}, 1'b1);
		u_host.recv(1'b0, d);
		chk("rd0", d, e0);
		u_host.recv(1'b1, d);
		chk("rd1", d, e1);
		u_host.stop();
	endtask : mem_rd
	task automatic s_pins;
		@(posedge CLK);
		TX_DISABLE_PIN <= 1'b0;
		wait_cyc(4);
		chk("laser", TX_LASER_ON, 8'h01);
		chk("fault", TX_FAULT_OE, 8'h01);
		chk("loss", RECEIVE_POWER_LOST_OE, 8'h01);
		chk("present", {MODULE_PRESENT_LINE_OE, MODULE_PRESENT_LINE_OUT}, 8'h02);
		@(posedge CLK);
		TX_DISABLE_DRIVEN <= 1'b0;
		LASER_FAULT <= 1'b1;
		RX_POWER_LOW <= 1'b1;
		wait_cyc(4);
		chk("laser_open", TX_LASER_ON, 8'h00);
		chk("fault", TX_FAULT_OE, 8'h00);
		chk("loss", RECEIVE_POWER_LOST_OE, 8'h00);
		@(posedge CLK);
		TX_DISABLE_DRIVEN <= 1'b1;
		TX_DISABLE_PIN <= 1'b1;
		LASER_FAULT <= 1'b0;
		RX_POWER_LOW <= 1'b0;
		wait_cyc(4);
		chk("laser_high", TX_LASER_ON, 8'h00);
	endtask : s_pins
	task automatic s_mem;
		mem_rd(ID_DEV_ADDR, 8'h05, ID_SEED ^ 8'h05, ID_SEED ^ 8'h06);
		mem_rd(DIAG_DEV_ADDR, CAL_LAST, DIAG_SEED ^ CAL_LAST, 8'hA7);
		mem_wr(DIAG_DEV_ADDR, CAL_FIRST, 8'h11, 8'h22);
		mem_rd(DIAG_DEV_ADDR, CAL_FIRST, DIAG_SEED ^ 8'h38, DIAG_SEED ^ 8'h39);
		mem_wr(DIAG_DEV_ADDR, USER_FIRST, 8'h3C, 8'hD2);
		mem_rd(DIAG_DEV_ADDR, USER_FIRST, 8'h3C, 8'hD2);
	endtask : s_mem
	task automatic s_irq;
		reg_wr(REG_STATUS, 8'hFF);
		reg_wr(REG_MASK, 8'h0F);
		reg_rd(REG_MASK);
		chk("mask", d, 8'h0F);
		// unknown device address is left unanswered
		u_host.start();
		tx({7'h52, 1'b0}, 1'b0);
		u_host.stop();
		reg_rd(REG_STATUS);
		chk("status", d, 8'h03);
		chk("irq", IRQ, 8'h01);
		reg_wr(REG_MASK, 8'h00);
		wait_cyc(1);
		chk("irq_masked", IRQ, 8'h00);
		reg_wr(REG_MASK, 8'h0F);
		reg_wr(REG_STATUS, 8'h03);
		reg_rd(REG_STATUS);
		chk("cleared", {d[3:0], 3'h0, IRQ}, 8'h00);
		reg_wr(REG_CTRL, 8'h03);
		wait_cyc(1);
		chk("forced", {TX_FAULT_OE, RECEIVE_POWER_LOST_OE}, 8'h00);
		reg_wr(REG_CTRL, 8'h00);
	endtask : s_irq
	initial
	begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 12000)
		begin
			err_count++;
			end_sim();
		end
	end
	initial
	begin
		{RST_B, LASER_FAULT, RX_POWER_LOW, REG_WR, REG_RD} = 5'h00;
		{CE, TX_DISABLE_PIN, TX_DISABLE_DRIVEN, MON_VALID} = 4'hF;
		MON_RAW = 80'hA7;
		REG_ADDR = 2'h0;
		REG_WDATA = 8'h00;
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
		s_pins();
		s_mem();
		s_irq();
		end_sim();
	end
endmodule : transceiver_mgmt_status_port_bench
`default_nettype wire
